// ===== occ_regs.vh
`ifndef OCC_REGS_VH
`define OCC_REGS_VH

// Register offset of the oscillator control register, byte address.
`define OCC_OSC_CTRL_ADDR 12'h000
`define OCC_ADDR_W 12

// Field positions inside the oscillator control register.
`define OCC_UNUSED_BIT 7
`define OCC_FREQ_MSB 6
`define OCC_FREQ_LSB 4
`define OCC_STARTUP_BIT 3
`define OCC_HFS_BIT 2
`define OCC_LFS_BIT 1
`define OCC_SCS_BIT 0

// Reset values.
`define OCC_FREQ_RST 3'h6
`define OCC_SCS_RST 1'b0
`define OCC_STARTUP_RST 1'b1
`define OCC_HFS_RST 1'b0
`define OCC_LFS_RST 1'b0

// Frequency select codes.
`define OCC_FREQ_8MHZ 3'h7
`define OCC_FREQ_4MHZ 3'h6
`define OCC_FREQ_2MHZ 3'h5
`define OCC_FREQ_1MHZ 3'h4
`define OCC_FREQ_500KHZ 3'h3
`define OCC_FREQ_250KHZ 3'h2
`define OCC_FREQ_125KHZ 3'h1
`define OCC_FREQ_31KHZ 3'h0

// Cycles after reset release before the straps are trusted.
`define OCC_STRAP_SETTLE 2'h3

`endif

// ===== occ_sync.v
`default_nettype none

module occ_sync #(
  parameter WIDTH = 6
) (
  // Clock and reset.
  input wire core_clk,
  input wire sys_rst,
  // Asynchronous levels in and synchronised levels out.
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // Two flip-flops; only the second stage is ever read by logic.
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

// ===== occ_clk_switch.v
`default_nettype none
`include "occ_regs.vh"

module occ_clk_switch (
  // Clock and reset.
  input wire core_clk,
  input wire sys_rst,
  // Start-up load of the initial source.
  input wire load_init,
  input wire init_internal,
  // Requested source and frequency.
  input wire req_internal,
  input wire [2:0] req_freq,
  // Synchronised readiness of each source.
  input wire hf_ok,
  input wire lf_ok,
  input wire cfg_ok,
  // Source actually in use.
  output reg cur_internal,
  output reg [2:0] cur_freq,
  output wire switching
);

  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;

  reg [1:0] state;
  reg [1:0] next_state;
  wire differs;
  wire target_ok;

  // Readiness of the source that a given selection would use.
  function src_ready;
    input internal;
    input [2:0] freq;
    input hf;
    input lf;
    input cfg;
    begin
      if (!internal)
        src_ready = cfg;
      else if (freq == `OCC_FREQ_31KHZ)
        src_ready = lf;
      else
        src_ready = hf;
    end
  endfunction

  // A frequency change only matters while the internal source is wanted.
  assign differs = (req_internal != cur_internal) ||
    (req_internal && (req_freq != cur_freq));
  assign target_ok = src_ready(req_internal, req_freq, hf_ok, lf_ok, cfg_ok);
  assign switching = state[1];

  // The old source keeps running until the new one is stable.
  always @*
  begin
    next_state = state;
    case (state)
      ST_RUN:
        if (differs)
          next_state = ST_WAIT;
      ST_WAIT:
        if (!differs || target_ok)
          next_state = ST_RUN;
      default:
        next_state = ST_RUN;
    endcase
  end

  // Commit happens in one edge, so the source and divider change together.
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= ST_RUN;
      cur_internal <= 1'b0;
      cur_freq <= `OCC_FREQ_RST;
    end
    else if (load_init)
    begin
      state <= ST_RUN;
      cur_internal <= init_internal;
      cur_freq <= req_freq;
    end
    else
    begin
      state <= next_state;
      if (state == ST_WAIT && differs && target_ok)
      begin
        cur_internal <= req_internal;
        cur_freq <= req_freq;
      end
    end
  end

endmodule

`default_nettype wire

// ===== occ_top.v
`default_nettype none
`include "occ_regs.vh"

module occ_top (
  // Clock and reset.
  input wire core_clk,
  input wire sys_rst,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Oscillator status and configuration straps, asynchronous.
  input wire hf_osc_stable,
  input wire lf_osc_stable,
  input wire cfg_osc_ready,
  input wire cfg_crystal_mode,
  input wire cfg_two_speed_en,
  input wire cfg_fail_safe_en,
  // Clock selection towards the clock tree.
  output wire sys_clk_internal,
  output wire [2:0] sys_freq_sel,
  output wire clk_switching,
  output wire hf_osc_enable,
  output wire lf_osc_enable
);

  reg [2:0] internal_freq_select;
  reg system_clock_select;
  reg startup_source_status;
  reg high_freq_stable;
  reg low_freq_stable;
  reg [1:0] settle_cnt;
  reg strap_loaded;
  reg load_init;
  wire [5:0] sync_q;
  wire hf_ok;
  wire lf_ok;
  wire cfg_ok;
  wire crystal_q;
  wire two_speed_q;
  wire fail_safe_q;
  wire init_internal;
  wire cur_internal;
  wire [2:0] cur_freq;
  wire addr_hit;
  wire wr_en;
  wire [2:0] wr_freq;
  wire freq_change;
  wire [7:0] reg_value;

  // Every asynchronous oscillator status and strap input passes two flip-flops before use.
  occ_sync #(
    .WIDTH(6)
  ) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in({cfg_fail_safe_en, cfg_two_speed_en, cfg_crystal_mode,
      cfg_osc_ready, lf_osc_stable, hf_osc_stable}),
    .sync_out(sync_q)
  );

  assign hf_ok = sync_q[0];
  assign lf_ok = sync_q[1];
  assign cfg_ok = sync_q[2];
  assign crystal_q = sync_q[3];
  assign two_speed_q = sync_q[4];
  assign fail_safe_q = sync_q[5];

  // Start on the internal oscillator in the two cases that demand it.
  assign init_internal = (two_speed_q && crystal_q) || fail_safe_q;

  // Straps are caught after release, once the synchroniser has settled,
  // because an asynchronous reset may only load constants.
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      settle_cnt <= 2'h0;
      strap_loaded <= 1'b0;
      load_init <= 1'b0;
    end
    else
    begin
      load_init <= 1'b0;
      if (!strap_loaded)
      begin
        if (settle_cnt == `OCC_STRAP_SETTLE)
        begin
          strap_loaded <= 1'b1;
          load_init <= 1'b1;
        end
        else
          settle_cnt <= settle_cnt + 2'h1;
      end
    end
  end

  // Switch control keeps the running source until the target is stable.
  occ_clk_switch u_switch (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load_init(load_init),
    .init_internal(init_internal),
    .req_internal(system_clock_select || !strap_loaded ||
      (cur_internal && !cfg_ok)),
    .req_freq(internal_freq_select),
    .hf_ok(hf_ok),
    .lf_ok(lf_ok),
    .cfg_ok(cfg_ok),
    .cur_internal(cur_internal),
    .cur_freq(cur_freq),
    .switching(clk_switching)
  );

  assign sys_clk_internal = cur_internal;
  assign sys_freq_sel = cur_freq;

  // Keep both the running internal oscillator and the one requested through system_clock_select powered,
  // so the old one never stops before the new one has taken over.
  assign hf_osc_enable = (cur_internal && cur_freq != `OCC_FREQ_31KHZ) ||
    (system_clock_select && internal_freq_select != `OCC_FREQ_31KHZ);
  assign lf_osc_enable = 1'b1;

  // APB decode; zero wait states, so pready is always high.
  assign pready = 1'b1;
  assign addr_hit = (paddr == `OCC_OSC_CTRL_ADDR);
  assign wr_en = psel && penable && pwrite && addr_hit && pstrb[0];
  assign wr_freq = pwdata[`OCC_FREQ_MSB:`OCC_FREQ_LSB];
  assign freq_change = wr_en && (wr_freq != internal_freq_select);

  // Only the frequency field and the clock select bit are writable;
  // bit 7 and the status bits ignore the write data.
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      internal_freq_select <= `OCC_FREQ_RST;
      system_clock_select <= `OCC_SCS_RST;
    end
    else if (wr_en)
    begin
      internal_freq_select <= wr_freq;
      system_clock_select <= pwdata[`OCC_SCS_BIT];
    end
  end

  // Stability flags follow the oscillators, but a request for a new high frequency
  // clears the high-frequency flag for one cycle, and again while the switch is under way until it has landed on it.
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      high_freq_stable <= `OCC_HFS_RST;
      low_freq_stable <= `OCC_LFS_RST;
    end
    else
    begin
      if (freq_change && wr_freq != `OCC_FREQ_31KHZ)
        high_freq_stable <= 1'b0;
      else if (clk_switching && cur_freq != internal_freq_select &&
        internal_freq_select != `OCC_FREQ_31KHZ)
        high_freq_stable <= 1'b0;
      else
        high_freq_stable <= hf_ok;
      if (freq_change && wr_freq == `OCC_FREQ_31KHZ)
        low_freq_stable <= 1'b0;
      else
        low_freq_stable <= lf_ok;
    end
  end

  // Start-up status shows which source really drives the system clock.
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      startup_source_status <= `OCC_STARTUP_RST;
    else if (load_init)
      startup_source_status <= !init_internal;
    else if (strap_loaded)
      startup_source_status <= !cur_internal;
  end

  // Read image; the unimplemented top bit is a constant zero.
  assign reg_value = {1'b0, internal_freq_select, startup_source_status,
    high_freq_stable, low_freq_stable, system_clock_select};

  // Read data and error are captured in the setup cycle, so they come
  // from flip-flops and are stable through the access phase.
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr <= !addr_hit;
      if (addr_hit && !pwrite)
        prdata <= {24'h000000, reg_value};
      else
        prdata <= 32'h00000000;
    end
  end

endmodule

`default_nettype wire

// ===== occ_chk.sv
`default_nettype none
module occ_chk (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [31:0] prdata,
  // Oscillator status and clock selection.
  input wire logic hf_osc_stable,
  input wire logic lf_osc_stable,
  input wire logic cfg_osc_ready,
  input wire logic sys_clk_internal,
  input wire logic [2:0] sys_freq_sel,
  input wire logic clk_switching
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [2:0] wr_freq;
  logic wr_scs;
  // Write setups load zero read data, so only read setups are judged.
  wire rd_setup = psel && !penable && !pwrite && paddr == 12'h000;
  // Shadow of the writable fields, so every read can be judged.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_freq <= 3'h6;
      wr_scs <= 1'b0;
    end
    else if (psel && penable && pready && pwrite && paddr == 12'h000
             && pstrb[0])
    begin
      wr_freq <= pwdata[6:4];
      wr_scs <= pwdata[0];
    end
  end
  a_bit7_zero: assert property (prdata[31:7] == 25'h0)
    else $error("upper read bits not zero");
  a_reg_match: assert property (rd_setup |=>
    prdata[6:4] == $past(wr_freq) && prdata[0] == $past(wr_scs))
    else $error("writable fields differ from last write");
  a_startup_src: assert property (rd_setup && $stable(sys_clk_internal)
    |=> prdata[3] == !$past(sys_clk_internal))
    else $error("startup bit does not match source");
  a_freq_applied: assert property (wr_scs && $stable(wr_scs)
    && $stable(wr_freq) && !clk_switching
    |-> sys_clk_internal && sys_freq_sel == wr_freq)
    else $error("internal frequency not applied");
  a_ext_selected: assert property ((!wr_scs && !clk_switching
    && cfg_osc_ready)[*6] |-> !sys_clk_internal)
    else $error("configured source not in use");
  a_hf_flag: assert property ((!hf_osc_stable)[*5] ##0 rd_setup
    |=> !prdata[2])
    else $error("high flag set while oscillator unstable");
  a_lf_flag: assert property ((!lf_osc_stable)[*5] ##0 rd_setup
    |=> !prdata[1])
    else $error("low flag set while oscillator unstable");
  a_reset_vals: assert property ($fell(sys_rst)
    |-> sys_freq_sel == 3'h6 && !sys_clk_internal)
    else $error("wrong selection after reset");
  c_write: cover property (psel && penable && pwrite);
  c_switch: cover property ($fell(clk_switching));
  c_unmapped: cover property (psel && !penable && paddr != 12'h000);
endmodule
bind occ_top occ_chk i_chk (.core_clk, .sys_rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .hf_osc_stable,
  .lf_osc_stable, .cfg_osc_ready, .sys_clk_internal, .sys_freq_sel,
  .clk_switching);
`default_nettype wire

// ===== testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic hf_osc_stable = 1'b0;
  logic lf_osc_stable = 1'b0;
  logic cfg_rdy = 1'b1;
  logic fail_safe = 1'b0;
  logic hf_en, lf_en;
  int int_m = 0;
  logic pready, pslverr, sys_clk_internal, clk_switching, err;
  logic [31:0] prdata, rd, d;
  logic [2:0] sys_freq_sel;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int freq_m = 6;
  int scs_m = 0;

  // Straps start low so the first start-up source is the configured one.
  occ_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .hf_osc_stable(hf_osc_stable), .lf_osc_stable(lf_osc_stable),
    .cfg_osc_ready(cfg_rdy), .cfg_crystal_mode(1'b0),
    .cfg_two_speed_en(1'b0), .cfg_fail_safe_en(fail_safe),
    .sys_clk_internal(sys_clk_internal), .sys_freq_sel(sys_freq_sel),
    .clk_switching(clk_switching), .hf_osc_enable(hf_en),
    .lf_osc_enable(lf_en));

  // Clock of 40 ns.
  always #20 core_clk = ~core_clk;

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, input logic [3:0] st);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register image predicted from the model and the oscillator inputs.
  function automatic logic [31:0] exp_reg();
    int v;
    v = freq_m * 16 + (scs_m != 0 || int_m != 0 ? 0 : 8) + scs_m;
    v = v + (hf_osc_stable ? 4 : 0) + (lf_osc_stable ? 2 : 0);
    return 32'(v);
  endfunction

  task automatic rd_chk();
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk_word(rd, exp_reg());
  endtask

  // Sampling at the falling edge keeps clear of register updates.
  task automatic wait_sw();
    int n;
    n = 0;
    @(negedge core_clk);
    while ((clk_switching !== 1'b0 || sys_clk_internal !== scs_m[0]
            || (scs_m != 0 && sys_freq_sel !== 3'(freq_m))) && n < 60)
    begin
      @(negedge core_clk);
      n++;
    end
    repeat (8) @(negedge core_clk);
  endtask

  // A hang is cut short here and counted as a mismatch.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      summarize();
    end
  end

  initial
  begin
    void'($urandom(32'h1334));
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd_chk();
    chk_bit(lf_en, 1'b1);
    hf_osc_stable <= 1'b1;
    lf_osc_stable <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd_chk();
    apb(1'b1, 12'h004, 32'h71, 4'hf);
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    chk_bit(err, 1'b1);
    chk_word(rd, 32'h0);
    apb(1'b1, 12'h000, 32'h71, 4'he);
    rd_chk();
    for (int i = 7; i >= 0; i--)
    begin
      d = $urandom();
      d[6:4] = 3'(i);
      d[0] = 1'b1;
      apb(1'b1, 12'h000, d, 4'($urandom()) | 4'h1);
      freq_m = i;
      scs_m = 1;
      wait_sw();
      chk_bit(sys_clk_internal, 1'b1);
      chk_word(32'(sys_freq_sel), 32'(i));
      chk_bit(hf_en, i != 0);
      rd_chk();
    end
    d = $urandom();
    d[6:4] = 3'h6;
    d[0] = 1'b0;
    apb(1'b1, 12'h000, d, 4'hf);
    freq_m = 6;
    scs_m = 0;
    wait_sw();
    chk_bit(sys_clk_internal, 1'b0);
    chk_bit(hf_en, 1'b0);
    rd_chk();
    // Second reset with the fail-safe strap: start on the internal source
    // and stay there until the configured source reports ready.
    sys_rst <= 1'b1;
    fail_safe <= 1'b1;
    cfg_rdy <= 1'b0;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    freq_m = 6;
    scs_m = 0;
    int_m = 1;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    chk_bit(sys_clk_internal, 1'b1);
    rd_chk();
    cfg_rdy <= 1'b1;
    int_m = 0;
    wait_sw();
    chk_bit(sys_clk_internal, 1'b0);
    rd_chk();
    summarize();
  end
endmodule
`default_nettype wire
